/* File: verification/acr_analog_model.sv */
/*
  analog front end model: four fixed input levels and an ideal comparator.
  assumes the sequencer shows its trial word on dac_level_i at each tick.
*/
module acr_analog_model
  import acr_pkg::*;
#(
  parameter logic [31:0] LEVELS = 32'hff00a53c
)
(
  input wire logic clk_i,
  input wire logic [3:0] pin_en_i,
  input wire logic [1:0] sel_i,
  input wire logic [7:0] dac_level_i,
  output logic cmp_hi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_r = 1'b0;
  logic [7:0] level;

  // a pin left as a port pin gives a meaningless, changing answer
  always @(posedge clk_i)
    toggle_r <= ~toggle_r;

  // ideal comparator on the selected, enabled input
  always_comb
  begin
    level = LEVELS[8 * sel_i +: 8];
    cmp_hi_o = pin_en_i[sel_i] ? (level >= dac_level_i) : toggle_r;
  end
endmodule

/* File: verification/acr_top_bench.sv */
/*
  self-checking bench for the converter control block.
  assumes the analog model stands in for the pins and comparator.
*/
module acr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import acr_pkg::*;
  localparam logic [31:0] LEVELS = 32'hff00a53c;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [3:0] wdata = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] div = 8'h00;
  logic [3:0] rdata;
  logic cmp_hi;
  logic [3:0] pin_en;
  logic [1:0] sel;
  logic [7:0] dac;
  logic busy;
  logic irq;
  int errors = 0;
  int compares = 0;

  // 20 MHz clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  acr_top dut (
    .clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .prescaler_divisor_i(div), .cmp_hi_i(cmp_hi),
    .analog_pin_enable_o(pin_en), .analog_input_sel_o(sel), .dac_level_o(dac),
    .sample_hold_o(), .conv_busy_o(busy), .conv_irq_o(irq)
  );

  acr_analog_model #(.LEVELS(LEVELS)) model (
    .clk_i(clk), .pin_en_i(pin_en), .sel_i(sel), .dac_level_i(dac), .cmp_hi_o(cmp_hi)
  );

  // ****************************************
  // bus and check helpers
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({4'h0, rdata}, {4'h0, exp});
  endtask

  // start, read control back while busy, then count cycles to idle
  task automatic convert(input logic [1:0] ch, input logic osc, output int n);
    wr_reg(ACR_CTRL_ADDR, {1'b1, osc, ch});
    rd_chk(ACR_CTRL_ADDR, {1'b0, osc, ch});
    check({7'h0, busy}, 8'h01);
    n = 0;
    while (busy === 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h0, busy}, 8'h00);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(ACR_CTRL_ADDR, 4'h0);
    rd_chk(ACR_PINEN_ADDR, 4'h0);
    rd_chk(ACR_MASK_ADDR, 4'h0);
    rd_chk(ACR_FLAG_ADDR, 4'h0);
    rd_chk(16'hff6c, 4'h0);
    check({pin_en, sel, busy, irq}, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_regs();
    wr_reg(ACR_PINEN_ADDR, 4'ha);
    rd_chk(ACR_PINEN_ADDR, 4'ha);
    check({4'h0, pin_en}, 8'h0a);
    wr_reg(ACR_CTRL_ADDR, 4'h6);
    rd_chk(ACR_CTRL_ADDR, 4'h6);
    check({6'h0, sel}, 8'h02);
    wr_reg(ACR_MASK_ADDR, 4'hf);
    rd_chk(ACR_MASK_ADDR, 4'h1);
    wr_reg(ACR_FLAG_ADDR, 4'he);
    rd_chk(ACR_FLAG_ADDR, 4'h0);
    wr_reg(ACR_MASK_ADDR, 4'h0);
    rd_chk(ACR_MASK_ADDR, 4'h0);
    // start bit written as zero must leave the converter idle
    wr_reg(ACR_CTRL_ADDR, 4'h7);
    repeat (4) @(posedge clk);
    check({7'h0, busy}, 8'h00);
    $display("register test done");
  endtask

  task automatic t_conv();
    int n;
    // pins routed before any conversion runs
    wr_reg(ACR_PINEN_ADDR, 4'hf);
    for (int ch = 0; ch < 4; ch++)
    begin
      convert(ch[1:0], 1'b1, n);
      rd_chk(ACR_FLAG_ADDR, 4'h1);
      rd_chk(ACR_RES_LO_ADDR, LEVELS[8 * ch +: 4]);
      rd_chk(ACR_RES_HI_ADDR, LEVELS[8 * ch + 4 +: 4]);
      wr_reg(ACR_RES_LO_ADDR, ~LEVELS[8 * ch +: 4]);
      rd_chk(ACR_RES_LO_ADDR, LEVELS[8 * ch +: 4]);
      check({7'h0, irq}, 8'h00);
      wr_reg(ACR_MASK_ADDR, 4'h1);
      rd_chk(ACR_MASK_ADDR, 4'h1);
      check({7'h0, irq}, 8'h01);
      wr_reg(ACR_FLAG_ADDR, 4'h0);
      rd_chk(ACR_FLAG_ADDR, 4'h1);
      wr_reg(ACR_FLAG_ADDR, 4'h1);
      rd_chk(ACR_FLAG_ADDR, 4'h0);
      check({7'h0, irq}, 8'h00);
      wr_reg(ACR_MASK_ADDR, 4'h0);
    end
    $display("conversion test done");
  endtask

  task automatic t_timing();
    int n0;
    int n1;
    int n3;
    int no;
    // divisor only changed while idle
    div <= 8'h00;
    convert(2'h1, 1'b0, n0);
    div <= 8'h01;
    convert(2'h1, 1'b0, n1);
    div <= 8'h03;
    convert(2'h1, 1'b0, n3);
    convert(2'h1, 1'b1, no);
    check(n1[7:0], no[7:0]);
    check({7'h0, n3 > n1 && n1 > n0}, 8'h01);
    rd_chk(ACR_RES_LO_ADDR, LEVELS[11:8]);
    $display("timing test done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_conv();
    t_timing();
    print_verdict();
  end

  // tests need well under 2000 cycles; allow ten times that
  initial
  begin
    #(50 * 20000);
    errors++;
    print_verdict();
  end
endmodule

/* File: verilog/acr_pkg.sv */
/*
  constants for the converter control block: register offsets, field positions,
  reset values and timing counts.
  assumes a 16-bit i/o address and 4-bit data on the register port.
*/
package acr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] ACR_CTRL_ADDR = 16'hff68;
  localparam logic [15:0] ACR_PINEN_ADDR = 16'hff69;
  localparam logic [15:0] ACR_RES_LO_ADDR = 16'hff6a;
  localparam logic [15:0] ACR_RES_HI_ADDR = 16'hff6b;
  localparam logic [15:0] ACR_MASK_ADDR = 16'hffe7;
  localparam logic [15:0] ACR_FLAG_ADDR = 16'hfff7;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ACR_CHS_LSB = 0;
  localparam int ACR_CLKSEL_BIT = 2;
  localparam int ACR_START_BIT = 3;
  localparam int ACR_IRQ_BIT = 0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] ACR_CHS_RST = 2'h0;
  localparam logic ACR_CLKSEL_RST = 1'b0;
  localparam logic [3:0] ACR_PINEN_RST = 4'h0;
  localparam logic ACR_MASK_RST = 1'b0;
  localparam logic ACR_FLAG_RST = 1'b0;
  // ****************************************
  // timing
  // ****************************************
  // successive approximation: one sample tick then 8 bit steps, plus hold margin
  localparam logic [4:0] ACR_CONV_TICKS = 5'h14;
  localparam logic [7:0] ACR_PRS_RST = 8'h00;
  typedef enum logic [1:0] {ACR_IDLE, ACR_SAMPLE, ACR_CONVERT, ACR_STORE} acr_state_t;
endpackage

/* File: verilog/acr_sar.sv */
/*
  successive-approximation sequencer with gated conversion-clock ticks.
  assumes the analog comparator answer cmp_hi is valid at each tick.
*/
module acr_sar
  import acr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  acr_sar_if.sar sar
);
  typedef struct packed {
    acr_state_t st;
    logic [7:0] div_cnt;
    logic div_tgl;
    logic [3:0] bit_idx;
    logic [7:0] approx;
    logic done;
  } acr_sar_state_t;

  acr_sar_state_t s_r;
  acr_sar_state_t s_nxt;
  logic tick;

  // ****************************************
  // conversion clock enable
  // ****************************************
  // ticks only while busy: the divider is held idle between conversions
  always_comb
  begin
    if (sar.clk_sel)
      tick = s_r.div_tgl; // osc/2
    else
      tick = (s_r.div_cnt == sar.prs_div); // osc/(div+1)
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (s_r.st != ACR_IDLE)
    begin
      s_nxt.div_tgl = ~s_r.div_tgl;
      s_nxt.div_cnt = tick ? 8'h00 : s_r.div_cnt + 8'h01;
    end
    case (s_r.st)
      ACR_IDLE:
      begin
        s_nxt.div_cnt = 8'h00;
        s_nxt.div_tgl = 1'b0;
        if (sar.start)
        begin
          // trial index 8 marks the sampling window for the hold switch
          s_nxt.st = ACR_SAMPLE;
          s_nxt.bit_idx = 4'h8;
        end
      end
      ACR_SAMPLE:
        if (tick)
        begin
          s_nxt.st = ACR_CONVERT;
          s_nxt.bit_idx = 4'h7;
          s_nxt.approx = 8'h80;
        end
      ACR_CONVERT:
        if (tick)
        begin
          // keep the trial bit when input is at or above the dac level
          if (!sar.cmp_hi)
            s_nxt.approx[s_r.bit_idx[2:0]] = 1'b0;
          if (s_r.bit_idx == 4'h0)
            s_nxt.st = ACR_STORE;
          else
          begin
            s_nxt.bit_idx = s_r.bit_idx - 4'h1;
            s_nxt.approx[s_r.bit_idx[2:0] - 3'h1] = 1'b1;
          end
        end
      ACR_STORE:
      begin
        s_nxt.done = 1'b1;
        s_nxt.st = ACR_IDLE;
      end
      default:
        s_nxt.st = ACR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r.st <= ACR_IDLE;
      s_r.div_cnt <= 8'h00;
      s_r.div_tgl <= 1'b0;
      s_r.bit_idx <= 4'h0;
      s_r.approx <= 8'h00;
      s_r.done <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  assign sar.busy = (s_r.st != ACR_IDLE);
  assign sar.done = s_r.done;
  assign sar.result = s_r.approx;
  assign sar.trial = s_r.bit_idx;
  assign sar.tick = tick & (s_r.st != ACR_IDLE);
endmodule

/* File: verilog/acr_sar_if.sv */
/*
  interface between the register block and the successive-approximation sequencer.
  assumes both ends share clk_i.
*/
interface acr_sar_if;
  logic start;
  logic clk_sel;
  logic [7:0] prs_div;
  logic busy;
  logic done;
  logic [7:0] result;
  logic [3:0] trial;
  logic cmp_hi;
  logic tick;
  modport ctrl (output start, output clk_sel, output prs_div, input busy, input done,
    input result, input trial, input tick);
  modport sar (input start, input clk_sel, input prs_div, output busy, output done,
    output result, output trial, output tick, input cmp_hi);
endinterface

/* File: verilog/acr_top.sv */
/*
  converter control and status registers with the conversion sequencer.
  assumes a cpu port with one-cycle strobes and read data in the next cycle only.
*/
// Design decision made here: the address-and-strobe port.
// Contract
// - four pin enables route port pins to the converter; clear at reset.
// - two-bit channel select picks input 0..3; resets to zero.
// - clock select 1 picks osc/2, 0 picks prescaler; readable, reset 0.
// - writing start 1 while idle begins conversion of the selected channel; 0, or 1 while busy, ignored.
// - start bit is write-only and always reads zero.
// - 8-bit result in two read-only nibbles, low nibble at lower address.
// - result is not reset; undefined until first conversion completes.
// - interrupt mask is read-write, 1 enables, clears at reset.
// - completion sets the flag regardless of mask; cleared at reset.
// - interrupt request only while flag and mask are both one.
// - writing 1 clears the flag, writing 0 leaves it.
// - unused upper three bits of mask and flag read as zero.
// - prescaler-clocked conversion time scales with divisor setting.
// - flag sets in the same cycle as the result is written, marking conversion end.
// - prescaler conversion clock is oscillator over divisor plus one.
// - eight-bit successive approximation with sample and hold.
module acr_top
  import acr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [3:0] rdata_o,
  input wire logic [7:0] prescaler_divisor_i,
  input wire logic cmp_hi_i,
  output logic [3:0] analog_pin_enable_o,
  output logic [1:0] analog_input_sel_o,
  output logic [7:0] dac_level_o,
  output logic sample_hold_o,
  output logic conv_busy_o,
  output logic conv_irq_o
);
  typedef struct packed {
    logic [1:0] chs;
    logic clk_sel;
    logic [3:0] pin_en;
    logic [7:0] result;
    logic mask;
    logic flag;
    logic start;
    logic [3:0] rdata;
  } acr_regs_t;

  acr_regs_t r_r;
  acr_regs_t r_nxt;
  acr_sar_if sif ();

  // address compare used by both the write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  acr_sar u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sar(sif)
  );
  assign sif.cmp_hi = cmp_hi_i;
  assign sif.start = r_r.start;
  assign sif.clk_sel = r_r.clk_sel;
  assign sif.prs_div = prescaler_divisor_i;

  // ****************************************
  // register file
  // ****************************************
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.start = 1'b0;
    r_nxt.rdata = 4'h0;
    if (wr_i)
    begin
      if (hit(addr_i, ACR_CTRL_ADDR))
      begin
        r_nxt.chs = wdata_i[ACR_CHS_LSB +: 2];
        r_nxt.clk_sel = wdata_i[ACR_CLKSEL_BIT];
        // a start while busy is dropped so a running conversion is not torn
        r_nxt.start = wdata_i[ACR_START_BIT] & ~sif.busy;
      end
      if (hit(addr_i, ACR_PINEN_ADDR))
        r_nxt.pin_en = wdata_i;
      if (hit(addr_i, ACR_MASK_ADDR))
        r_nxt.mask = wdata_i[ACR_IRQ_BIT];
      if (hit(addr_i, ACR_FLAG_ADDR) && wdata_i[ACR_IRQ_BIT])
        r_nxt.flag = 1'b0;
    end
    // completion wins over a same-cycle clear
    if (sif.done)
    begin
      r_nxt.result = sif.result;
      r_nxt.flag = 1'b1;
    end
    if (rd_i)
    begin
      if (hit(addr_i, ACR_CTRL_ADDR))
        r_nxt.rdata = {1'b0, r_r.clk_sel, r_r.chs};
      else if (hit(addr_i, ACR_PINEN_ADDR))
        r_nxt.rdata = r_r.pin_en;
      else if (hit(addr_i, ACR_RES_LO_ADDR))
        r_nxt.rdata = r_r.result[3:0];
      else if (hit(addr_i, ACR_RES_HI_ADDR))
        r_nxt.rdata = r_r.result[7:4];
      else if (hit(addr_i, ACR_MASK_ADDR))
        r_nxt.rdata = {3'h0, r_r.mask};
      else if (hit(addr_i, ACR_FLAG_ADDR))
        r_nxt.rdata = {3'h0, r_r.flag};
    end
  end

  // result is left out of reset on purpose: it is undefined until first done
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_r.chs <= ACR_CHS_RST;
      r_r.clk_sel <= ACR_CLKSEL_RST;
      r_r.pin_en <= ACR_PINEN_RST;
      r_r.mask <= ACR_MASK_RST;
      r_r.flag <= ACR_FLAG_RST;
      r_r.start <= 1'b0;
      r_r.rdata <= 4'h0;
      r_r.result <= r_nxt.result;
    end
    else
      r_r <= r_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o = r_r.rdata;
  assign analog_pin_enable_o = r_r.pin_en;
  assign analog_input_sel_o = r_r.chs;
  assign dac_level_o = sif.result;
  // hold switch open only in the sampling step, not in the last bit or store
  assign sample_hold_o = sif.busy && (sif.trial == 4'h8);
  assign conv_busy_o = sif.busy;
  assign conv_irq_o = r_r.flag & r_r.mask;

  // ****************************************
  // checks
  // ****************************************
  ctrl_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == ACR_CTRL_ADDR |=> rdata_o[3] == 1'b0)
    else $error("start bit read as one");
  hi_bits_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == ACR_MASK_ADDR || addr_i == ACR_FLAG_ADDR) |=> rdata_o[3:1] == 3'h0)
    else $error("unused bits not zero");
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.done |=> r_r.flag)
    else $error("flag not set on completion");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == ACR_FLAG_ADDR && wdata_i[0] && !sif.done |=> !r_r.flag)
    else $error("flag not cleared");
  flag_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == ACR_FLAG_ADDR && !wdata_i[0] && r_r.flag |=> r_r.flag)
    else $error("flag cleared by zero");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.done && r_r.mask && !(wr_i && addr_i == ACR_MASK_ADDR) |=> conv_irq_o)
    else $error("irq not raised on completion");
  start_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == ACR_CTRL_ADDR && wdata_i[3] && !conv_busy_o |=> ##1 conv_busy_o)
    else $error("start did not begin");
  result_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.done |=> r_r.result == $past(sif.result))
    else $error("result not stored");
  result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !sif.done |=> $stable(r_r.result))
    else $error("result changed");
  pin_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == ACR_PINEN_ADDR |=> rdata_o == $past(analog_pin_enable_o))
    else $error("pin enable readback");
  mask_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == ACR_MASK_ADDR |=> r_r.mask == $past(wdata_i[0]))
    else $error("mask not written");
  chs_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == ACR_CTRL_ADDR |=> analog_input_sel_o == $past(wdata_i[1:0]))
    else $error("channel not written");
  osc_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(conv_busy_o) && r_r.clk_sel |-> conv_busy_o [*8] ##1 conv_busy_o [*8])
    else $error("osc2 conversion too short");
  idle_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !conv_busy_o |=> $stable(dac_level_o))
    else $error("converter stepped while idle");
  hold_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(conv_busy_o) |-> sample_hold_o)
    else $error("sample window not opened");
  hold_close_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_hold_o && sif.tick |=> !sample_hold_o && conv_busy_o)
    else $error("sample window not closed");
endmodule
